// File: common/trig_map.svh
// Constants of the measurement trigger controller
// What this block does
// R1: Continuous mode runs processing nonstop, ignoring any trigger.
// R2: Retriggered mode starts a new run on each trigger event that arrives after the previous run has ended.
// R3: One-shot mode runs once from the first trigger, then idles.
// R4: One-shot with exponential averaging runs from first trigger until stop.
// R5: Timed mode stores at intervals from start time for a set count.
// R6: Vibration meter mode offers only continuous and timed modes.
// R7: Retriggered or one-shot in vibration meter mode acts as continuous.
// R8: Instantaneous-value spectrum mode gets no trigger gating at all.
// R9: Level source triggers when the input reaches the threshold.
// R10: Threshold settable only in eighths of full scale.
// R11: Slope selects positive or negative approach to the threshold.
// R12: External source triggers on falling edge; low pulse at least 10 us. The code triggers on the first low cycle and never checks the width.
// R13: Pretrigger starts run data one eighth frame before the trigger.
// R14: No post-trigger delay; data never starts after the trigger.
// R15: Level trigger fires on crossing between consecutive samples.
// R16: Circular buffer keeps at least one eighth frame of samples.
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH
`define CLK_MHZ            250
`define EXT_MIN_LOW_NS     10000
`define EXT_MIN_LOW_CYC    ((`EXT_MIN_LOW_NS * `CLK_MHZ) / 1000)
`define LEVEL_STEP_SHIFT   3
`define PRE_FRAC_SHIFT     3
`define MODE_CONT          2'h0
`define MODE_RETRIG        2'h1
`define MODE_ONESHOT       2'h2
`define MODE_TIMED         2'h3
`endif

// File: common/trig_pkg.sv
// Types of the measurement trigger controller
package trig_pkg;
  typedef struct packed {
    logic [1:0]  mode;
    logic        src_ext;
    logic [2:0]  level_step;
    logic        slope_neg;
    logic        pretrig;
    logic        meter_mode;
    logic        inst_spectrum;
    logic        exp_avg;
  } trig_cfg_t;
  typedef struct packed {
    logic [31:0] start_delay;
    logic [31:0] interval;
    logic [15:0] store_count;
  } timed_cfg_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_RUN  = 4'h4,
    ST_DONE = 4'h8
  } trig_state_t;
endpackage : trig_pkg

// File: logic/sample_ring.sv
// Circular sample buffer supplying pretrigger history
`timescale 1ns/10ps
`include "trig_map.svh"
module sample_ring
  import trig_pkg::*;
#(
  parameter int DW    = 16,
  parameter int DEPTH = 256
)
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     wr_en,
  input  wire logic [DW-1:0]            wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_back,
  output logic      [DW-1:0]            rd_data,
  output logic      [$clog2(DEPTH)-1:0] wr_ptr
);
  logic [DW-1:0] mem [DEPTH];

  // ----------------------------------------
  // Write side
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      wr_ptr <= '0;
    else if (wr_en)
      wr_ptr <= wr_ptr + 1'b1; // see R16
  end

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_ptr] <= wr_data;
  end

  // ----------------------------------------
  // Read side
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rd_data <= '0;
    else if (rd_back == '0)
      rd_data <= wr_data; // see R14
    else
      rd_data <= mem[wr_ptr - rd_back]; // see R13
  end
endmodule : sample_ring

// File: logic/measurement_trigger_control.sv
// Trigger controller deciding when analysis processing runs
`timescale 1ns/10ps
`include "trig_map.svh"
module measurement_trigger_control
  import trig_pkg::*;
#(
  parameter int DW         = 16,
  parameter int FRAME_LEN  = 2048,
  parameter int RUN_LEN    = 2048
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire trig_cfg_t        cfg,
  input  wire timed_cfg_t       tcfg,
  input  wire logic             meas_start,
  input  wire logic             run_stop,
  input  wire logic             sample_valid,
  input  wire logic signed [DW-1:0] sample,
  input  wire logic             ext_trig_n,
  output logic                  proc_active,
  output logic                  proc_start,
  output logic                  store_pulse,
  output logic                  trig_pulse,
  output logic                  data_valid,
  output logic signed [DW-1:0]  data_out,
  output logic                  done
);
  localparam int PRE_LEN = FRAME_LEN >> `PRE_FRAC_SHIFT;
  localparam int RING    = 2 * PRE_LEN;
  localparam int AW      = $clog2(RING);
  localparam int EXT_CYC = (`EXT_MIN_LOW_CYC < 1) ? 1 : `EXT_MIN_LOW_CYC;
  localparam logic [AW:0] FILL_TOP = (AW+1)'(PRE_LEN);

  trig_state_t              state;
  logic [1:0]               eff_mode;
  logic signed [DW-1:0]     threshold;
  logic signed [DW-1:0]     prev_sample;
  logic                     prev_ok;
  logic                     level_hit;
  logic [2:0]               ext_sync;
  logic                     ext_level;
  logic                     ext_hit;
  logic [$clog2(EXT_CYC+1)-1:0] ext_low_cnt;
  logic                     trig_event;
  logic [31:0]              run_cnt;
  logic [31:0]              tmr;
  logic [15:0]              stores;
  logic [AW-1:0]            rd_back;
  logic [AW-1:0]            wr_ptr;
  logic signed [DW-1:0]     ring_q;
  logic [AW:0]              fill_cnt;
  logic                     hist_ok;

  // ----------------------------------------
  // Effective mode
  // ----------------------------------------
  always_comb
  begin
    eff_mode = cfg.mode;
    if (cfg.inst_spectrum)
      eff_mode = `MODE_CONT; // see R8
    else if (cfg.meter_mode && cfg.mode != `MODE_TIMED)
      eff_mode = `MODE_CONT; // see R6 see R7
  end

  // ----------------------------------------
  // Level trigger
  // ----------------------------------------
  always_comb
  begin
    threshold = DW'(signed'({cfg.level_step, {(DW-3){1'b0}}})); // see R10
    if (!cfg.slope_neg)
      level_hit = prev_ok && prev_sample < threshold && sample >= threshold; // see R9 see R11
    else
      level_hit = prev_ok && prev_sample > threshold && sample <= threshold; // see R11
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prev_sample <= '0;
      prev_ok     <= 1'b0;
    end
    else if (sample_valid)
    begin
      prev_sample <= sample; // see R15
      prev_ok     <= 1'b1;
    end
  end

  // ----------------------------------------
  // External trigger
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ext_sync  <= 3'h7;
      ext_level <= 1'b1;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_trig_n};
      if (ext_sync[1] == ext_sync[2])
        ext_level <= ext_sync[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ext_low_cnt <= '0;
      ext_hit     <= 1'b0;
    end
    else
    begin
      ext_hit <= 1'b0;
      if (ext_level)
        ext_low_cnt <= '0;
      else if (ext_low_cnt != EXT_CYC[$bits(ext_low_cnt)-1:0])
      begin
        ext_low_cnt <= ext_low_cnt + 1'b1;
        ext_hit     <= (ext_low_cnt == '0); // see R12
      end
    end
  end

  assign trig_event = cfg.src_ext ? ext_hit : (sample_valid && level_hit);

  // ----------------------------------------
  // Pretrigger history
  // ----------------------------------------
  always_comb
  begin
    rd_back = cfg.pretrig ? AW'(PRE_LEN) : '0; // see R13 see R14
  end

  sample_ring #(
    .DW    (DW),
    .DEPTH (RING)
  ) u_ring (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (sample_valid),
    .wr_data (sample),
    .rd_back (rd_back),
    .rd_data (ring_q),
    .wr_ptr  (wr_ptr)
  );

  // ----------------------------------------
  // History fill tracking
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fill_cnt <= '0;
      hist_ok  <= 1'b0;
    end
    else
    begin
      hist_ok <= (fill_cnt == FILL_TOP); // see R16
      if (sample_valid && fill_cnt != FILL_TOP)
        fill_cnt <= fill_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_out   <= '0;
      data_valid <= 1'b0;
    end
    else
    begin
      if (hist_ok || !cfg.pretrig)
        data_out <= ring_q; // see R13
      else
        data_out <= '0;
      data_valid <= proc_active && sample_valid;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state       <= ST_IDLE;
      proc_active <= 1'b0;
      proc_start  <= 1'b0;
      store_pulse <= 1'b0;
      trig_pulse  <= 1'b0;
      done        <= 1'b0;
      run_cnt     <= '0;
      tmr         <= '0;
      stores      <= '0;
    end
    else
    begin
      proc_start  <= 1'b0;
      store_pulse <= 1'b0;
      trig_pulse  <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          proc_active <= 1'b0;
          if (meas_start)
          begin
            done   <= 1'b0;
            tmr    <= tcfg.start_delay;
            stores <= tcfg.store_count;
            if (eff_mode == `MODE_CONT)
            begin
              state       <= ST_RUN; // see R1
              proc_active <= 1'b1;
              proc_start  <= 1'b1;
            end
            else
              state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (run_stop)
            state <= ST_IDLE;
          else if (eff_mode == `MODE_TIMED)
          begin
            if (tmr == '0)
            begin
              state       <= ST_RUN; // see R5
              proc_active <= 1'b1;
              proc_start  <= 1'b1;
              tmr         <= tcfg.interval;
            end
            else
              tmr <= tmr - 1'b1;
          end
          else if (trig_event)
          begin
            state       <= ST_RUN; // see R2 see R3
            proc_active <= 1'b1;
            proc_start  <= 1'b1;
            trig_pulse  <= 1'b1;
            run_cnt     <= RUN_LEN - 1;
          end
        end
        ST_RUN:
        begin
          if (run_stop)
          begin
            state       <= ST_IDLE;
            proc_active <= 1'b0;
          end
          else if (eff_mode == `MODE_CONT)
            proc_active <= 1'b1; // see R1
          else if (eff_mode == `MODE_TIMED)
          begin
            if (tmr == '0)
            begin
              store_pulse <= 1'b1;
              tmr         <= tcfg.interval;
              if (stores <= 16'h0001)
              begin
                state       <= ST_DONE; // see R5
                proc_active <= 1'b0;
              end
              stores <= stores - 1'b1;
            end
            else
              tmr <= tmr - 1'b1;
          end
          else if (eff_mode == `MODE_ONESHOT && cfg.exp_avg)
            proc_active <= 1'b1; // see R4
          else if (run_cnt == '0)
          begin
            proc_active <= 1'b0;
            if (eff_mode == `MODE_RETRIG)
              state <= ST_WAIT; // see R2
            else
              state <= ST_DONE; // see R3
          end
          else
            run_cnt <= run_cnt - 1'b1;
        end
        ST_DONE:
        begin
          proc_active <= 1'b0;
          done        <= 1'b1;
          if (meas_start)
          begin
            state <= ST_IDLE;
            done  <= 1'b0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule : measurement_trigger_control

// File: bench/trig_chk.sv
// Port checker of the trigger controller
`timescale 1ns/10ps
module trig_chk
  import trig_pkg::*;
#(
  parameter int DW = 16
)
(
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire trig_cfg_t            cfg,
  input wire timed_cfg_t           tcfg,
  input wire logic                 meas_start,
  input wire logic                 run_stop,
  input wire logic                 sample_valid,
  input wire logic signed [DW-1:0] sample,
  input wire logic                 ext_trig_n,
  input wire logic                 proc_active,
  input wire logic                 proc_start,
  input wire logic                 store_pulse,
  input wire logic                 trig_pulse,
  input wire logic                 done
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic cont_like;
  assign cont_like = cfg.mode == 2'h0 ||
    (cfg.mode != 2'h3 && (cfg.meter_mode || cfg.inst_spectrum));
  sequence pin_high_s;
    (cfg.src_ext && ext_trig_n) [*8];
  endsequence
  sequence idle_start_s;
    cont_like && meas_start && !proc_active && !done && !run_stop;
  endsequence
  start_in_run_a: assert property (proc_start |-> proc_active)
    else $error("start without active run");
  trig_starts_a: assert property (trig_pulse |-> proc_start)
    else $error("trigger did not start run");
  cont_start_a: assert property (idle_start_s |=> proc_start)
    else $error("free run did not start");
  cont_holds_a: assert property (cont_like && proc_active && !run_stop |=> proc_active)
    else $error("free run stopped");
  avg_holds_a: assert property (cfg.mode == 2'h2 && cfg.exp_avg && proc_active && !run_stop
    |=> proc_active)
    else $error("averaging run stopped");
  once_only_a: assert property (done |-> !proc_start && !proc_active)
    else $error("run after done");
  pin_quiet_a: assert property (pin_high_s |=> !trig_pulse)
    else $error("trigger with pin high");
  store_gap_a: assert property (store_pulse && tcfg.interval == 32'h3
    |=> (!store_pulse) [*3])
    else $error("stores too close");
  stop_ends_a: assert property (run_stop |=> !proc_active)
    else $error("run survived stop");
endmodule : trig_chk
bind measurement_trigger_control trig_chk #(.DW(DW)) chk_u (.clk(clk), .reset_n(reset_n),
  .cfg(cfg), .tcfg(tcfg), .meas_start(meas_start), .run_stop(run_stop),
  .sample_valid(sample_valid), .sample(sample), .ext_trig_n(ext_trig_n),
  .proc_active(proc_active), .proc_start(proc_start), .store_pulse(store_pulse),
  .trig_pulse(trig_pulse), .done(done));

// File: bench/trig_src.sv
// Model of the sampled input and the external trigger pin
`timescale 1ns/10ps
`include "trig_map.svh"
module trig_src
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  output logic               sample_valid,
  output logic signed [15:0] sample,
  output logic               ext_trig_n,
  output logic               rising
);
  // ------------------------------------------------------------
  // Triangle wave and pin pulse
  // ------------------------------------------------------------
  initial ext_trig_n = 1'b1;
  always_ff @(posedge clk)
  begin
    sample_valid <= reset_n;
    if (!reset_n)
    begin
      sample <= 16'sh0;
      rising <= 1'b1;
    end
    else
    begin
      sample <= rising ? sample + 16'sh0400 : sample - 16'sh0400;
      if (sample == 16'sh7800) rising <= 1'b0;
      if (sample == -16'sh7800) rising <= 1'b1;
    end
  end
  task automatic ext_pulse;
    ext_trig_n = 1'b0;
    repeat (`EXT_MIN_LOW_CYC) @(posedge clk);
    #1 ext_trig_n = 1'b1;
  endtask : ext_pulse
endmodule : trig_src

// File: bench/testbench.sv
// Self-checking testbench of the trigger controller
`timescale 1ns/10ps
module testbench
  import trig_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, meas_start = 1'b0, run_stop = 1'b0;
  logic sample_valid, ext_trig_n, rising, proc_active, proc_start;
  logic store_pulse, trig_pulse, data_valid, done;
  logic signed [15:0] sample, data_out;
  logic signed [15:0] hist [10];
  trig_cfg_t  cfg = '0;
  timed_cfg_t tcfg = '0;
  int mismatches = 0, checks_done = 0, starts = 0, stores = 0, bad_dir = 0;
  trig_cfg_t  free_cfg [3] = '{'{mode:2'h0, default:'0}, '{mode:2'h1, meter_mode:1'b1,
    default:'0}, '{mode:2'h2, inst_spectrum:1'b1, level_step:3'h2, default:'0}};
  // ------------------------------------------------------------
  // Design, source and tasks
  // ------------------------------------------------------------
  measurement_trigger_control #(.DW(16), .FRAME_LEN(64), .RUN_LEN(8)) dut_u (.clk(clk),
    .reset_n(reset_n), .cfg(cfg), .tcfg(tcfg), .meas_start(meas_start),
    .run_stop(run_stop), .sample_valid(sample_valid), .sample(sample),
    .ext_trig_n(ext_trig_n), .proc_active(proc_active), .proc_start(proc_start),
    .store_pulse(store_pulse), .trig_pulse(trig_pulse), .data_valid(data_valid),
    .data_out(data_out), .done(done));
  trig_src src_u (.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
    .sample(sample), .ext_trig_n(ext_trig_n), .rising(rising));
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    if (proc_start === 1'b1) starts = starts + 1;
    if (store_pulse === 1'b1) stores = stores + 1;
    if (trig_pulse === 1'b1 && !cfg.src_ext && rising === cfg.slope_neg) bad_dir = bad_dir + 1;
    for (int i = 9; i > 0; i--)
      hist[i] = hist[i-1];
    hist[0] = sample;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches = mismatches + 1;
    end
  endtask : check
  task automatic go(input trig_cfg_t c);
    cfg = c;
    meas_start = 1'b1;
    step(done === 1'b1 ? 2 : 1);
    meas_start = 1'b0;
  endtask : go
  task automatic stop;
    run_stop = 1'b1;
    step(1);
    run_stop = 1'b0;
    step(2);
    check(32'(proc_active), 32'h0);
    starts = 0;
    stores = 0;
    bad_dir = 0;
  endtask : stop
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    end_of_test;
  end
  initial
  begin
    step(8);
    reset_n = 1'b1;
    step(1);
    foreach (free_cfg[i])
    begin
      go(free_cfg[i]);
      step(300);
      check(32'(proc_active), 32'h1);
      check(32'(starts), 32'h1);
      check(32'(data_valid), 32'h1);
      stop;
    end
    for (int s = 0; s < 2; s++)
    begin
      go('{mode:2'h1, level_step:3'h2, slope_neg:s[0], pretrig:s[0], default:'0});
      step(400);
      check(32'(starts > 1), 32'h1);
      check(32'(bad_dir), 32'h0);
      check(32'(data_out), 32'(hist[s ? 9 : 1]));
      stop;
    end
    go('{mode:2'h2, src_ext:1'b1, default:'0});
    src_u.ext_pulse;
    step(50);
    check(32'(done), 32'h1);
    src_u.ext_pulse;
    step(50);
    check(32'(starts), 32'h1);
    stop;
    go('{mode:2'h2, exp_avg:1'b1, level_step:3'h2, default:'0});
    step(300);
    check(32'(proc_active), 32'h1);
    check(32'(starts), 32'h1);
    stop;
    tcfg = '{start_delay:32'h5, interval:32'h3, store_count:16'h3};
    go('{mode:2'h3, meter_mode:1'b1, default:'0});
    step(60);
    check(32'(stores), 32'h3);
    check(32'(done), 32'h1);
    stop;
    end_of_test;
  end
endmodule : testbench
